// [dv/highway_source.sv]
// Purpose: far-side model of the highway timing, makes frame sync and bit clock pulses on request
// Assumes: one request at a time, only while busy_out is low
// Notes: both lines idle low between pulses, the bit clock stands still outside frames
`timescale 1ns/1ps
module highway_source
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic fs_req_in,
  input wire logic bit_req_in,
  output logic bit_clk_out,
  output logic frame_sync_out,
  output logic busy_out
);
  logic [2:0] cnt_r; // pulse phase countdown
  logic [2:0] cnt_nxt;
  logic is_fs_r; // current pulse is a frame sync
  logic is_fs_nxt;
  // three cycles high then three low, so the pins outlast the two-stage sync
  always_comb begin
    cnt_nxt = cnt_r;
    is_fs_nxt = is_fs_r;
    if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end else if (fs_req_in || bit_req_in) begin
      cnt_nxt = 3'h6;
      is_fs_nxt = fs_req_in;
    end
  end
  // state registers only
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_r <= 3'h0;
      is_fs_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      is_fs_r <= is_fs_nxt;
    end
  end
  assign bit_clk_out = (cnt_r > 3'h3) && !is_fs_r;
  assign frame_sync_out = (cnt_r > 3'h3) && is_fs_r;
  assign busy_out = (cnt_r != 3'h0);
endmodule // highway_source

// [dv/pcm_slot_offset_tx_gain_regs_test.sv]
// Purpose: self-checking bench for the slot offset and tx gain registers
// Assumes: single AHB-Lite master, hready fed back from hreadyout
// Notes: read results go through a queue checked by a separate monitor
`timescale 1ns/1ps
module pcm_slot_offset_tx_gain_regs_test;
  import pcm_slot_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic hreadyout_out, hresp_out, bit_clk_in, frame_sync_in, enable_out, tx_act, rx_act, src_busy;
  logic [31:0] hrdata_out;
  logic signed [GAIN_DB_W-1:0] tx_gain_db_out;
  logic fs_req = 1'b0;
  logic bit_req = 1'b0;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic rd_pend = 1'b0; // read data phase in flight
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] seed = 8'h29;
  logic [7:0] v;
  logic signed [5:0] e;
  pcm_slot_offset_tx_gain_regs i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .hrdata_out(hrdata_out), .bit_clk_in(bit_clk_in), .frame_sync_in(frame_sync_in),
    .highway_transfer_enable_out(enable_out), .tx_slot_active_out(tx_act), .rx_slot_active_out(rx_act),
    .tx_gain_db_out(tx_gain_db_out));
  highway_source i_src (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .fs_req_in(fs_req), .bit_req_in(bit_req),
    .bit_clk_out(bit_clk_in), .frame_sync_out(frame_sync_in), .busy_out(src_busy));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // byte address of a register index
  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction
  // one comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // closing report
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // wait for hready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    wait_rdy();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy();
  endtask
  // read with its expectation noted first
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  // one highway pulse, then let the synchroniser settle
  task automatic pulse(input logic fs);
    int n;
    fs_req <= fs;
    bit_req <= !fs;
    @(posedge ref_clk_in);
    fs_req <= 1'b0;
    bit_req <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (src_busy && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
    repeat (5) @(posedge ref_clk_in);
    #1;
  endtask
  // monitor: completes read data phases against the queue
  always @(posedge ref_clk_in) begin
    if (rd_pend && hreadyout_out === 1'b1) begin
      rd_pend = 1'b0;
      check({31'h0, hresp_out}, 32'h0);
      if (exp_q.size() == 0) check(hrdata_out, 32'hFFFF_FFFF);
      else check(hrdata_out, exp_q.pop_front());
    end
    if (hsel_in && htrans_in[1] && hreadyout_out === 1'b1 && !hwrite_in) rd_pend = 1'b1;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    // reset values
    for (int i = 0; i < 5; i++) rd(adr(IDX_TX_LOW + 8'(i)), 32'h0);
    $display("reset values done");
    // random write and read back, reserved bits masked
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed;
      bus(1'b1, adr(IDX_TX_LOW), {24'hFFFFFF, v});
      bus(1'b1, adr(IDX_TX_HIGH), {24'h0, ~v});
      bus(1'b1, adr(IDX_RX_LOW), {24'h0, ~v});
      bus(1'b1, adr(IDX_RX_HIGH), {24'h0, v});
      bus(1'b1, adr(IDX_TX_GAIN2), {24'h0, v});
      rd(adr(IDX_TX_LOW), {24'h0, v});
      rd(adr(IDX_TX_HIGH), {30'h0, ~v[1:0]});
      rd(adr(IDX_RX_LOW), {24'h0, ~v});
      rd(adr(IDX_RX_HIGH), {30'h0, v[1:0]});
      rd(adr(IDX_TX_GAIN2), {27'h0, v[4:0]});
      rd(32'h0000_0400 | {24'h0, v[7:2], 2'b00}, 32'h0);
    end
    $display("register access done");
    // every direction and magnitude of the second gain stage
    for (int i = 0; i < 32; i++) begin
      bus(1'b1, adr(IDX_TX_GAIN2), {27'h0, 5'(i)});
      e = (i[4] == 1'b0) ? ((i[3:2] == 2'b11) ? 6'sh0C : 6'(i[3:0])) : -6'(i[3:0]);
      repeat (2) @(posedge ref_clk_in);
      #1;
      check({26'h0, tx_gain_db_out}, {26'h0, e});
    end
    $display("gain table done");
    // offsets first, then enable, then one frame
    bus(1'b1, adr(IDX_TX_LOW), 32'h02);
    bus(1'b1, adr(IDX_TX_HIGH), 32'h01);
    bus(1'b1, adr(IDX_RX_LOW), 32'h05);
    bus(1'b1, adr(IDX_RX_HIGH), 32'h00);
    bus(1'b1, adr(IDX_CONTROL), 32'h20);
    rd(adr(IDX_CONTROL), 32'h0000_0020);
    @(posedge ref_clk_in);
    #1;
    check({31'h0, enable_out}, 32'h1);
    pulse(1'b1);
    for (int k = 0; k <= 260; k++) begin
      if (k > 0) pulse(1'b0);
      check({31'h0, tx_act}, {31'h0, k >= 258});
      check({31'h0, rx_act}, {31'h0, k >= 5});
    end
    rd(adr(IDX_STATUS), (32'h0000_0104 << STAT_CNT_LSB) | (32'h1 << STAT_TX_BIT) | (32'h1 << STAT_RX_BIT));
    bus(1'b1, adr(IDX_STATUS), 32'hFFFF_FFFF);
    rd(adr(IDX_TX_LOW), 32'h0000_0002);
    bus(1'b1, adr(IDX_CONTROL), 32'h00);
    repeat (2) @(posedge ref_clk_in);
    #1;
    check({30'h0, tx_act, rx_act}, 32'h0);
    $display("slot timing done");
    repeat (4) @(posedge ref_clk_in);
    check(exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule // pcm_slot_offset_tx_gain_regs_test

// [hdl/pcm_slot_offset_tx_gain_regs.sv]
// Purpose: slot offset and second-stage tx gain registers on AHB-Lite
// Assumes: one master, hready equals this slave's hreadyout
// Notes: writes take no wait, reads add one wait state
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module pcm_slot_offset_tx_gain_regs
  import pcm_slot_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic bit_clk_in,
  input wire logic frame_sync_in,
  output logic highway_transfer_enable_out,
  output logic tx_slot_active_out,
  output logic rx_slot_active_out,
  output logic signed [GAIN_DB_W-1:0] tx_gain_db_out
);
  // bus phase state
  bus_phase_type ph_r, ph_nxt;
  logic [7:0] idx_r, idx_nxt; // register index of the data phase
  logic hit_r, hit_nxt; // index lies in the mapped window
  logic [31:0] rdata_r, rdata_nxt; // read data flop
  logic accept; // address phase taken this edge
  logic wr_en; // write data phase completing

  // register state
  logic [OFFSET_W-1:0] tx_offset_r, tx_offset_nxt;
  logic [OFFSET_W-1:0] rx_offset_r, rx_offset_nxt;
  logic tx_gain_direction_r, tx_gain_direction_nxt;
  logic [3:0] tx_gain_magnitude_r, tx_gain_magnitude_nxt;
  logic enable_r, enable_nxt; // highway transfer enable
  logic signed [GAIN_DB_W-1:0] gain_db_r, gain_db_nxt;

  // timer outputs
  logic tx_act, rx_act;
  logic [OFFSET_W-1:0] bit_count;

  // the code is a whole-decibel step; the sample path that applies it lies outside this slice
  // gain law of the second stage, in whole decibels
  function automatic logic signed [GAIN_DB_W-1:0] gain_law(input logic dir, input logic [3:0] mag);
    logic signed [GAIN_DB_W-1:0] db;
    db = '0;
    if (mag == 4'h0) begin // [RL8]
      db = '0;
    end else if (dir) begin // [RL6]
      // attenuation is linear up to all ones
      db = -$signed({2'b00, mag}); // [RL10] [RL7]
    end else if (mag >= GAIN_SAT_MAG) begin
      // 11xx codes all clip to the ceiling
      db = GAIN_SAT_DB; // [RL9]
    end else begin
      db = $signed({2'b00, mag}); // [RL7]
    end
    return db;
  endfunction

  // read mux; unmapped and reserved bits return zero
  function automatic logic [31:0] read_word(input logic [7:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      IDX_CONTROL: w[ENABLE_BIT] = enable_r;
      IDX_TX_LOW: w[7:0] = tx_offset_r[7:0];
      IDX_TX_HIGH: w[1:0] = tx_offset_r[9:8]; // [RL1] [RL13]
      IDX_RX_LOW: w[7:0] = rx_offset_r[7:0]; // [RL3]
      IDX_RX_HIGH: w[1:0] = rx_offset_r[9:8]; // [RL4] [RL13]
      IDX_TX_GAIN2: begin
        w[GAIN_DIR_BIT] = tx_gain_direction_r; // [RL13]
        w[3:0] = tx_gain_magnitude_r;
      end
      IDX_STATUS: begin
        // live view of the slot timer
        // a read may land on a bit clock edge, so the count is only a snapshot
        w[STAT_TX_BIT] = tx_act;
        w[STAT_RX_BIT] = rx_act;
        w[STAT_CNT_LSB +: OFFSET_W] = bit_count;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // address phase is taken when selected with an active htrans and hready high
  // hready low means a stretched bus, so nothing is taken then
  assign accept = hsel_in && htrans_in[1] && hready_in;
  assign wr_en = (ph_r == PH_WRITE) && hit_r;

  // next bus phase and read data
  always_comb begin
    ph_nxt = ph_r;
    idx_nxt = idx_r;
    hit_nxt = hit_r;
    rdata_nxt = rdata_r;
    case (ph_r)
      PH_READ_WAIT: begin
        // read one cycle after the address so a prior write is seen
        rdata_nxt = hit_r ? read_word(idx_r) : 32'h0000_0000;
        ph_nxt = PH_READ_DONE;
      end
      default: begin
        if (accept) begin
          idx_nxt = haddr_in[9:2];
          // hsize other than word is taken as word; lanes 7:0 carry data
          hit_nxt = (haddr_in[31:10] == 22'h000000) && (haddr_in[1:0] == 2'h0);
          ph_nxt = hwrite_in ? PH_WRITE : PH_READ_WAIT;
        end else begin
          ph_nxt = PH_IDLE;
        end
      end
    endcase
  end

  // bus phase registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ph_r <= PH_IDLE;
      idx_r <= 8'h00;
      hit_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ph_r <= ph_nxt;
      idx_r <= idx_nxt;
      hit_r <= hit_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // wait state only while a read is being fetched
  // writes never stall, so back to back writes run one per cycle
  // hresp stays okay; unmapped words read zero rather than erroring
  assign hreadyout_out = (ph_r != PH_READ_WAIT);
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_r;

  // next register values from write data phases
  always_comb begin
    tx_offset_nxt = tx_offset_r;
    rx_offset_nxt = rx_offset_r;
    tx_gain_direction_nxt = tx_gain_direction_r;
    tx_gain_magnitude_nxt = tx_gain_magnitude_r;
    enable_nxt = enable_r;
    if (wr_en) begin
      case (idx_r)
        // the enable has no lock; host sets offsets first [RL12]
        IDX_CONTROL: enable_nxt = hwdata_in[ENABLE_BIT];
        IDX_TX_LOW: tx_offset_nxt[7:0] = hwdata_in[7:0]; // [RL11]
        IDX_TX_HIGH: tx_offset_nxt[9:8] = hwdata_in[1:0]; // [RL1]
        IDX_RX_LOW: rx_offset_nxt[7:0] = hwdata_in[7:0]; // [RL3]
        IDX_RX_HIGH: rx_offset_nxt[9:8] = hwdata_in[1:0]; // [RL4]
        IDX_TX_GAIN2: begin
          tx_gain_direction_nxt = hwdata_in[GAIN_DIR_BIT]; // [RL6]
          tx_gain_magnitude_nxt = hwdata_in[3:0]; // [RL7]
        end
        default: begin
          // status and unmapped words ignore writes
          enable_nxt = enable_r;
        end
      endcase
    end
    // gain follows the fields one cycle later
    gain_db_nxt = gain_law(tx_gain_direction_r, tx_gain_magnitude_r);
  end

  // configuration registers
  // offsets reset to zero, so both windows open right at frame sync until written
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_offset_r <= {RST_HIGH, RST_TX_LOW}; // [RL11] [RL13]
      rx_offset_r <= {RST_HIGH, RST_RX_LOW}; // [RL13]
      tx_gain_direction_r <= RST_GAIN_DIR;
      tx_gain_magnitude_r <= RST_GAIN_MAG;
      enable_r <= 1'b0;
      gain_db_r <= '0;
    end else begin
      tx_offset_r <= tx_offset_nxt;
      rx_offset_r <= rx_offset_nxt;
      tx_gain_direction_r <= tx_gain_direction_nxt;
      tx_gain_magnitude_r <= tx_gain_magnitude_nxt;
      enable_r <= enable_nxt;
      gain_db_r <= gain_db_nxt;
    end
  end

  // offsets are held as high:low already, fed straight to the compare
  // offsets are live: a change in mid-frame can move a window within that frame
  slot_timer u_slot_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .bit_clk_in(bit_clk_in),
    .frame_sync_in(frame_sync_in),
    .enable_in(enable_r),
    .tx_offset_in(tx_offset_r), // [RL14]
    .rx_offset_in(rx_offset_r), // [RL14]
    .tx_active_out(tx_act),
    .rx_active_out(rx_act),
    .bit_count_out(bit_count)
  );

  assign highway_transfer_enable_out = enable_r;
  assign tx_slot_active_out = tx_act;
  assign rx_slot_active_out = rx_act;
  assign tx_gain_db_out = gain_db_r;

  // checks on register storage, reserved read bits and the gain law
  AST_TX_HIGH_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL1]
    (wr_en && idx_r == IDX_TX_HIGH) |=> tx_offset_r[9:8] == $past(hwdata_in[1:0]))
    else $error("tx offset high bits not stored");
  AST_TX_LOW_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL11]
    (wr_en && idx_r == IDX_TX_LOW) |=> tx_offset_r[7:0] == $past(hwdata_in[7:0]))
    else $error("tx offset low byte not stored");
  AST_RX_LOW_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL3]
    (wr_en && idx_r == IDX_RX_LOW) |=> rx_offset_r[7:0] == $past(hwdata_in[7:0]))
    else $error("rx offset low byte not stored");
  AST_RX_HIGH_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL4]
    (wr_en && idx_r == IDX_RX_HIGH) |=> rx_offset_r[9:8] == $past(hwdata_in[1:0]))
    else $error("rx offset high bits not stored");
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
    (ph_r == PH_READ_WAIT && (idx_r == IDX_TX_HIGH || idx_r == IDX_RX_HIGH))
      |=> rdata_r[31:2] == 30'h0000_0000 && hreadyout_out)
    else $error("reserved offset bits read non-zero");
  AST_GAIN_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL8]
    (tx_gain_magnitude_r == 4'h0) |=> gain_db_r == '0)
    else $error("zero magnitude gave non-zero gain");
  AST_GAIN_SAT: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL9]
    (!tx_gain_direction_r && tx_gain_magnitude_r[3:2] == 2'b11) |=> gain_db_r == GAIN_SAT_DB)
    else $error("gain did not saturate at twelve");
  AST_GAIN_UP: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL6]
    (!tx_gain_direction_r && tx_gain_magnitude_r < GAIN_SAT_MAG)
      |=> gain_db_r == $signed({2'b00, $past(tx_gain_magnitude_r)}))
    else $error("gain step is not one decibel");
  AST_ATTEN: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL10]
    tx_gain_direction_r |=> gain_db_r == -$signed({2'b00, $past(tx_gain_magnitude_r)}))
    else $error("attenuation step is not one decibel");
  AST_STEP: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL7]
    (tx_gain_direction_r && tx_gain_magnitude_r == 4'hF) |=> gain_db_r == -6'sh0F)
    else $error("full attenuation is not fifteen decibels");

  // storage checks for the remaining fields
  // enable bit lands where the host wrote it
  AST_ENABLE_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL12]
    (wr_en && idx_r == IDX_CONTROL) |=> enable_r == $past(hwdata_in[ENABLE_BIT]))
    else $error("transfer enable not stored");
  // both gain fields are taken from one write
  AST_GAIN_FIELDS_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL6]
    (wr_en && idx_r == IDX_TX_GAIN2) |=> tx_gain_direction_r == $past(hwdata_in[GAIN_DIR_BIT])
      && tx_gain_magnitude_r == $past(hwdata_in[3:0]))
    else $error("gain fields not stored");
  // the status word is read only
  AST_STATUS_NO_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
    (wr_en && idx_r == IDX_STATUS) |=> $stable(tx_offset_r) && $stable(rx_offset_r) && $stable(enable_r))
    else $error("status write changed a register");

  // a high or low write leaves the other half of the offset alone
  // tx high write keeps the low byte
  AST_TX_HIGH_KEEPS_LOW: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL14]
    (wr_en && idx_r == IDX_TX_HIGH) |=> tx_offset_r[7:0] == $past(tx_offset_r[7:0]))
    else $error("tx high write disturbed the low byte");
  // rx high write keeps the low byte
  AST_RX_HIGH_KEEPS_LOW: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL14]
    (wr_en && idx_r == IDX_RX_HIGH) |=> rx_offset_r[7:0] == $past(rx_offset_r[7:0]))
    else $error("rx high write disturbed the low byte");
  // rx low write keeps the high bits
  AST_RX_LOW_KEEPS_HIGH: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL14]
    (wr_en && idx_r == IDX_RX_LOW) |=> rx_offset_r[9:8] == $past(rx_offset_r[9:8]))
    else $error("rx low write disturbed the high bits");

  // bus handshake and read mux
  // a write data phase never stalls
  AST_WRITE_NO_WAIT: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL11]
    (ph_r == PH_WRITE) |-> hreadyout_out)
    else $error("write data phase stalled");
  // a read takes exactly one wait state
  AST_READ_ONE_WAIT: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
    (accept && !hwrite_in && ph_r != PH_READ_WAIT) |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state is not one cycle");
  // tx high bits read back in place
  AST_TX_READ_BACK: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL1]
    (ph_r == PH_READ_WAIT && hit_r && idx_r == IDX_TX_HIGH) |=> rdata_r[1:0] == $past(tx_offset_r[9:8]))
    else $error("tx high bits read back wrong");
  // rx high bits read back in place
  AST_RX_READ_BACK: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL4]
    (ph_r == PH_READ_WAIT && hit_r && idx_r == IDX_RX_HIGH) |=> rdata_r[1:0] == $past(rx_offset_r[9:8]))
    else $error("rx high bits read back wrong");
  // enable reads back at its own bit, low bits zero
  AST_CONTROL_READ: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL12]
    (ph_r == PH_READ_WAIT && hit_r && idx_r == IDX_CONTROL)
      |=> rdata_r[ENABLE_BIT] == $past(enable_r) && rdata_r[4:0] == 5'h00)
    else $error("control read back wrong");
  // gain word has nothing above the direction bit
  AST_GAIN_READ_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
    (ph_r == PH_READ_WAIT && idx_r == IDX_TX_GAIN2) |=> rdata_r[31:5] == 27'h000_0000)
    else $error("reserved gain bits read non-zero");
  // unmapped or misaligned words read zero
  AST_UNMAPPED_READ_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
    (ph_r == PH_READ_WAIT && !hit_r) |=> rdata_r == 32'h0000_0000)
    else $error("unmapped read non-zero");

  // the gain code stays inside its legal span
  AST_GAIN_SPAN: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL10]
    gain_db_r >= -6'sh0F && gain_db_r <= GAIN_SAT_DB)
    else $error("gain code out of range");
endmodule // pcm_slot_offset_tx_gain_regs

// [hdl/pcm_slot_pkg.sv]
// Purpose: constants for the slot offset and transmit gain register slice
// Assumes: AHB-Lite word access, one register per aligned word, 8 bits wide except status
// Notes: byte address of a register is four times its index
// Behaviour
// RL1: tx offset bits 9:8 in high register 1:0
// RL2: transmit starts after tx offset bit clocks
// RL3: rx offset bits 7:0 in low register
// RL4: rx offset bits 9:8 in high register 1:0
// RL5: receive sampling starts after rx offset clocks
// RL6: direction bit picks gain or attenuation
// RL7: one decibel per magnitude step
// RL8: magnitude zero means zero decibels
// RL9: gain saturates at twelve decibels
// RL10: attenuation reaches fifteen decibels at all ones
// RL11: tx offset low byte, reset to zero
// RL12: host programs offsets before enabling transfers
// RL13: reserved bits read zero, high registers reset zero
// RL14: high and low bytes form counter compare value
package pcm_slot_pkg;
  // register indices, byte address is index times four
  localparam logic [7:0] IDX_CONTROL = 8'h21;
  localparam logic [7:0] IDX_TX_LOW = 8'h22;
  localparam logic [7:0] IDX_TX_HIGH = 8'h23;
  localparam logic [7:0] IDX_RX_LOW = 8'h24;
  localparam logic [7:0] IDX_RX_HIGH = 8'h25;
  localparam logic [7:0] IDX_TX_GAIN2 = 8'h26;
  localparam logic [7:0] IDX_STATUS = 8'h3F;
  // field positions
  localparam int ENABLE_BIT = 5;
  localparam int GAIN_DIR_BIT = 4;
  localparam int STAT_TX_BIT = 0;
  localparam int STAT_RX_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  // widths
  localparam int OFFSET_W = 10;
  localparam int GAIN_DB_W = 6;
  // reset values
  localparam logic [7:0] RST_TX_LOW = 8'h00;
  localparam logic [1:0] RST_HIGH = 2'h0;
  localparam logic [7:0] RST_RX_LOW = 8'h00;
  localparam logic [3:0] RST_GAIN_MAG = 4'h0;
  localparam logic RST_GAIN_DIR = 1'b0;
  // gain ceiling in decibels when gaining up
  localparam logic signed [GAIN_DB_W-1:0] GAIN_SAT_DB = 6'sh0C;
  localparam logic [3:0] GAIN_SAT_MAG = 4'hC;
  // bus phases
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ_WAIT, PH_READ_DONE} bus_phase_type;
endpackage

// [hdl/slot_timer.sv]
// Purpose: bit clock counter and slot window compare
// Assumes: bit clock and frame sync are pins, slower than ref_clk_in / 4
// Notes: counter saturates so a missing frame sync cannot wrap a window
`timescale 1ns/1ps
module slot_timer
  import pcm_slot_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic bit_clk_in,
  input wire logic frame_sync_in,
  input wire logic enable_in,
  input wire logic [OFFSET_W-1:0] tx_offset_in,
  input wire logic [OFFSET_W-1:0] rx_offset_in,
  output logic tx_active_out,
  output logic rx_active_out,
  output logic [OFFSET_W-1:0] bit_count_out
);
  logic bc_s1_r, bc_s2_r, bc_d_r; // bit clock synchroniser and delay
  logic fs_s1_r, fs_s2_r, fs_d_r; // frame sync synchroniser and delay
  logic [OFFSET_W-1:0] cnt_r, cnt_nxt; // bit clocks since frame sync
  logic framed_r, framed_nxt; // a frame sync has been seen
  logic tx_r, tx_nxt, rx_r, rx_nxt; // slot windows
  logic bc_edge, fs_edge;

  // edges only from second stage onward
  assign bc_edge = bc_s2_r & ~bc_d_r;
  assign fs_edge = fs_s2_r & ~fs_d_r;

  // next counter and window values
  always_comb begin
    cnt_nxt = cnt_r;
    framed_nxt = framed_r & enable_in;
    if (fs_edge) begin // [RL14]
      cnt_nxt = '0;
      framed_nxt = enable_in;
    end else if (bc_edge && cnt_r != {OFFSET_W{1'b1}}) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // windows open once the count reaches the offset
    tx_nxt = framed_nxt && (cnt_nxt >= tx_offset_in); // [RL2]
    rx_nxt = framed_nxt && (cnt_nxt >= rx_offset_in); // [RL5]
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      {bc_s1_r, bc_s2_r, bc_d_r} <= 3'h0;
      {fs_s1_r, fs_s2_r, fs_d_r} <= 3'h0;
      cnt_r <= '0;
      framed_r <= 1'b0;
      tx_r <= 1'b0;
      rx_r <= 1'b0;
    end else begin
      bc_s1_r <= bit_clk_in;
      bc_s2_r <= bc_s1_r;
      bc_d_r <= bc_s2_r;
      fs_s1_r <= frame_sync_in;
      fs_s2_r <= fs_s1_r;
      fs_d_r <= fs_s2_r;
      cnt_r <= cnt_nxt;
      framed_r <= framed_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign tx_active_out = tx_r;
  assign rx_active_out = rx_r;
  assign bit_count_out = cnt_r;

  AST_TX_OPENS: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL2]
    $rose(tx_r) |-> framed_r && (cnt_r >= $past(tx_offset_in)))
    else $error("tx window opened before its offset");
  AST_RX_OPENS: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL5]
    $rose(rx_r) |-> framed_r && (cnt_r >= $past(rx_offset_in)))
    else $error("rx window opened before its offset");
  AST_SYNC_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL14]
    fs_edge |=> cnt_r == '0)
    else $error("frame sync did not clear the bit counter");
endmodule // slot_timer
